// File: src/bsc_chain_dev.sv
// Boundary-scan data register of the device end.
// Assumes the link clock tck clocks all of it and rst is
// held for a few tck edges; core inputs are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module bsc_chain_dev
  import bsc_pkg::*;
(
  // Link and reset
  bsc_link_if.dev                    link,
  input  wire logic                  rst,
  // Core side, normal mode drive
  input  wire logic [ANA_W-1:0]      coreAnalog,
  input  wire logic [PE_W-1:0]       corePortE,
  input  wire logic [REST_W-1:0]     coreRest,
  // Pad and analog observations
  input  wire logic                  compIn,
  input  wire logic [7:0]            portEPad,
  input  wire logic [REST_W-1:0]     restPad,
  // Driven cells
  output var  logic [ANA_W-1:0]      analogOut,
  output var  logic [PE_W-1:0]       portEOut,
  output var  logic [REST_W-1:0]     restOut,
  output var  logic [7:0]            portAData,
  output var  logic [9:0]            dacCode,
  output var  logic                  convEnable,
  output var  logic                  holdCtrl,
  output var  logic                  decision,
  output var  logic                  dummyBusy
);
  import bsc_pkg::*;

  // --------------------------------------------------
  // Declarations
  // --------------------------------------------------
  logic [CHAIN_LEN-1:0] chain_reg;
  logic [CHAIN_LEN-1:0] upd_reg;
  logic [CHAIN_LEN-1:0] cap_next;
  logic                 tdo_reg;
  logic [ANA_W-1:0]     anaS1_reg;
  logic [ANA_W-1:0]     anaS2_reg;
  logic [PE_W-1:0]      peS1_reg;
  logic [PE_W-1:0]      peS2_reg;
  logic [REST_W-1:0]    restS1_reg;
  logic [REST_W-1:0]    restS2_reg;
  logic [7:0]           padES1_reg;
  logic [7:0]           padES2_reg;
  logic [REST_W-1:0]    padRS1_reg;
  logic [REST_W-1:0]    padRS2_reg;
  logic                 compS1_reg;
  logic                 compS2_reg;
  logic                 decLatch_reg;
  logic                 extS1_reg;
  logic                 extS2_reg;
  logic                 extest;
  logic                 dummyStep;

  // Mode select is written at any controller cycle, so it is synchronised
  assign extest = extS2_reg;

  // --------------------------------------------------
  // Synchronisers for everything from outside tck
  // --------------------------------------------------
  // Two stages; only the second stage is read
  always_ff @(posedge link.tck) begin
    if (rst) begin
      anaS1_reg  <= '0;
      anaS2_reg  <= '0;
      peS1_reg   <= '0;
      peS2_reg   <= '0;
      restS1_reg <= '0;
      restS2_reg <= '0;
    end else begin
      anaS1_reg  <= coreAnalog;
      anaS2_reg  <= anaS1_reg;
      peS1_reg   <= corePortE;
      peS2_reg   <= peS1_reg;
      restS1_reg <= coreRest;
      restS2_reg <= restS1_reg;
    end
  end

  // Pads and comparator are observed, never driven
  always_ff @(posedge link.tck) begin
    if (rst) begin
      padES1_reg <= '0;
      padES2_reg <= '0;
      padRS1_reg <= '0;
      padRS2_reg <= '0;
      compS1_reg <= 1'b0;
      compS2_reg <= 1'b0;
      extS1_reg  <= 1'b0;
      extS2_reg  <= 1'b0;
    end else begin
      padES1_reg <= portEPad;
      padES2_reg <= padES1_reg;
      padRS1_reg <= restPad;
      padRS2_reg <= padRS1_reg;
      compS1_reg <= compIn;
      compS2_reg <= compS1_reg;
      extS1_reg  <= link.extestSel; // Not aligned to tck edges
      extS2_reg  <= extS1_reg;
    end
  end

  // --------------------------------------------------
  // Capture vector
  // --------------------------------------------------
  // Analog and port E control cells read back what they drive; the
  // other cells take the pad, the comparator or the decision latch
  always_comb begin
    cap_next = '0;
    cap_next[ANA_HI:ANA_LO] = analogOut;
    cap_next[CMP_OUT]  = compS2_reg;
    cap_next[CONV_DEC] = decLatch_reg;
    cap_next[PE0_DATA:PE0_DATA-PE_W+1] = portEOut;
    for (int p = 0; p < 8; p++) begin
      cap_next[bsc_pe_data(p)] = padES2_reg[p];
    end
    // Port F pins 4..7 have no cells in this range at all
    cap_next[PB0_DATA:0] = padRS2_reg;
  end

  // --------------------------------------------------
  // Shift path
  // --------------------------------------------------
  // TDI enters the top; bit 0 leaves first
  always_ff @(posedge link.tck) begin
    if (rst) begin
      chain_reg <= '0;
    end else if (link.captureDr) begin
      chain_reg <= cap_next;
    end else if (link.shiftDr) begin
      chain_reg <= {link.tdi, chain_reg[CHAIN_LEN-1:1]};
    end
  end

  // TDO moves on the falling edge, as the standard asks
  always_ff @(negedge link.tck) begin
    if (rst) begin
      tdo_reg <= 1'b0;
    end else begin
      tdo_reg <= chain_reg[0];
    end
  end

  assign link.tdo = tdo_reg;

  // --------------------------------------------------
  // Update stage
  // --------------------------------------------------
  // Outputs only move here, so shifting never glitches pins
  always_ff @(posedge link.tck) begin
    if (rst) begin
      upd_reg <= UPD_RST;
    end else if (link.updateDr) begin
      upd_reg <= chain_reg;
    end
  end

  // --------------------------------------------------
  // Output selection
  // --------------------------------------------------
  // External test drives from the update stage, else core
  always_ff @(posedge link.tck) begin
    if (rst) begin
      analogOut <= UPD_RST[ANA_HI:ANA_LO];
      portEOut  <= '0;
      restOut   <= '0;
    end else if (extest) begin
      analogOut <= upd_reg[ANA_HI:ANA_LO];
      portEOut  <= upd_reg[PE0_DATA:PE0_DATA-PE_W+1];
      restOut   <= upd_reg[PB0_DATA:0];
    end else begin
      analogOut <= anaS2_reg;
      portEOut  <= peS2_reg;
      restOut   <= restS2_reg;
    end
  end

  // Named converter controls taken from the selected source
  always_ff @(posedge link.tck) begin
    if (rst) begin
      dacCode    <= DAC_MID;
      convEnable <= 1'b0;
      holdCtrl   <= 1'b0;
    end else if (extest) begin
      dacCode    <= upd_reg[DAC_HI:DAC_LO];
      convEnable <= upd_reg[CONV_EN];
      holdCtrl   <= upd_reg[HOLD_BIT];
    end else begin
      dacCode    <= anaS2_reg[DAC_HI-ANA_LO:DAC_LO-ANA_LO];
      convEnable <= anaS2_reg[CONV_EN-ANA_LO];
      holdCtrl   <= anaS2_reg[HOLD_BIT-ANA_LO];
    end
  end

  // Port A data cells, pin 7 highest in the chain
  always_ff @(posedge link.tck) begin
    if (rst) begin
      portAData <= '0;
    end else begin
      for (int p = 0; p < 8; p++) begin
        portAData[p] <= extest ? upd_reg[bsc_pa_data(p)] : restS2_reg[bsc_pa_data(p)];
      end
    end
  end

  // --------------------------------------------------
  // Comparator decision latch
  // --------------------------------------------------
  // Low preload tracks the comparator; high freezes the result
  always_ff @(posedge link.tck) begin
    if (rst) begin
      decLatch_reg <= 1'b0;
    end else if (!analogOut[PRELOAD_N-ANA_LO]) begin
      decLatch_reg <= compS2_reg;
    end
  end

  // Visible copy of the held decision
  always_ff @(posedge link.tck) begin
    if (rst) begin
      decision <= 1'b0;
    end else begin
      decision <= decLatch_reg;
    end
  end

  // --------------------------------------------------
  // Dummy conversion
  // --------------------------------------------------
  // Only in normal mode; external test owns the converter
  bsc_conv_seq u_seq (
    .clk        (link.tck),
    .rst        (rst),
    .enable     (convEnable),
    .normalMode (!extest),
    .busy       (),
    .step       (dummyStep)
  );

  // Busy while the ten steps are still running
  always_ff @(posedge link.tck) begin
    if (rst) begin
      dummyBusy <= 1'b0;
    end else begin
      dummyBusy <= dummyStep;
    end
  end
endmodule : bsc_chain_dev
`default_nettype wire

// File: src/bsc_conv_seq.sv
// Dummy conversion sequencer of the converter.
// Assumes clk is the scan clock and enable is a registered level.
`timescale 1ns/1ns
`default_nettype none
module bsc_conv_seq
  import bsc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic enable,
  input  wire logic normalMode,
  // Status
  output var  logic busy,
  output var  logic step
);
  logic       enPrev_reg;
  logic [3:0] stepCnt_reg;

  // Rising enable in normal mode starts ten comparisons
  always_ff @(posedge clk) begin
    if (rst) begin
      enPrev_reg  <= 1'b0;
      stepCnt_reg <= 4'h0;
    end else begin
      enPrev_reg <= enable;
      if (enable && !enPrev_reg && normalMode) begin
        stepCnt_reg <= 4'(DUMMY_STEPS);
      end else if (stepCnt_reg != 4'h0) begin
        stepCnt_reg <= stepCnt_reg - 4'h1;
      end
    end
  end

  // Step held high one clock per comparison, ten clocks in a row
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      step <= 1'b0;
    end else begin
      busy <= (stepCnt_reg > 4'h1);
      step <= (stepCnt_reg != 4'h0);
    end
  end
endmodule : bsc_conv_seq
`default_nettype wire

// File: src/bsc_link_if.sv
// Scan link between the test controller and the chain.
// Assumes the controller drives every signal but tdo.
`timescale 1ns/1ns
`default_nettype none
interface bsc_link_if;
  logic tck;
  logic tdi;
  logic tdo;
  logic captureDr;
  logic shiftDr;
  logic updateDr;
  logic extestSel;
  modport dev (input tck, tdi, captureDr, shiftDr, updateDr, extestSel, output tdo);
  modport host (output tck, tdi, captureDr, shiftDr, updateDr, extestSel, input tdo);
endinterface : bsc_link_if
`default_nettype wire

// File: src/bsc_pkg.sv
// Constants shared by both ends of the boundary-scan link.
// Assumes a 198-cell chain and a 100 MHz controller clock.
package bsc_pkg;
  // --------------------------------------------------
  // Chain layout
  // --------------------------------------------------
  localparam int CHAIN_LEN = 198;
  localparam int ANA_HI    = 197;
  localparam int ANA_LO    = 158;
  localparam int ANA_W     = ANA_HI - ANA_LO + 1;
  localparam int CMP_IDLE  = 197;
  localparam int CMP_OUT   = 196;
  localparam int CMP_INPUT_MUX_SELECT = 195;
  localparam int CMP_BGIN  = 194;
  localparam int CONV_DEC  = 193;
  localparam int CONV_EN   = 188;
  localparam int DAC_HI    = 186;
  localparam int DAC_LO    = 177;
  localparam int HOLD_BIT  = 174;
  localparam int MUX_HI    = 172;
  localparam int MUX_LO    = 165;
  localparam int PASS_BIT  = 161;
  localparam int PRELOAD_N = 160;
  localparam int PE0_DATA  = 157;
  localparam int PE_W      = 24;
  localparam int PB0_DATA  = 133;
  localparam int REST_W    = 134;
  localparam int PA7_DATA  = 35;
  localparam logic [9:0] DAC_MID = 10'h200;
  localparam logic [CHAIN_LEN-1:0] UPD_RST =
    (198'h1 << MUX_LO) | (198'h1 << PASS_BIT) | (198'h1 << PRELOAD_N);
  // --------------------------------------------------
  // Timing
  // --------------------------------------------------
  localparam int DUMMY_STEPS = 10;
  localparam int REF_NS      = 10;
  localparam int SETTLE_NS   = 200;
  localparam int SETTLE_CYC  = (SETTLE_NS + REF_NS - 1) / REF_NS;
  localparam int TCK_DIV     = 16;
  localparam int TCK_HALF    = TCK_DIV / 2;
  // --------------------------------------------------
  // Controller registers (byte addresses)
  // --------------------------------------------------
  localparam logic [7:0] PAT_BASE   = 8'h00;
  localparam logic [7:0] CAP_BASE   = 8'h20;
  localparam logic [7:0] CTRL_ADDR  = 8'h40;
  localparam logic [7:0] STAT_ADDR  = 8'h44;
  localparam int         WORDS      = 7;
  localparam int CTRL_START  = 0;
  localparam int CTRL_EXTEST = 1;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_DEC    = 2;
  localparam int STAT_SETTLE = 3;

  // Data cell position of a port E pin
  function automatic int bsc_pe_data(input int pin);
    return PE0_DATA - 3 * pin;
  endfunction : bsc_pe_data

  // Port A runs backwards: pin 7 sits highest
  function automatic int bsc_pa_data(input int pin);
    return PA7_DATA - 3 * (7 - pin);
  endfunction : bsc_pa_data
endpackage : bsc_pkg

// File: src/bsc_test_ctrl.sv
// Boundary-scan test controller end of the link.
// Assumes ref_clk at 100 MHz; makes tck by division.
`timescale 1ns/1ns
`default_nettype none
module bsc_test_ctrl
  import bsc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  output var  logic [31:0] rdData,
  // Link
  bsc_link_if.host         link
);
  import bsc_pkg::*;

  typedef enum {ST_IDLE, ST_CAP, ST_SHIFT, ST_UPD} bsc_state_t;

  bsc_state_t           state_reg;
  logic [3:0]           div_reg;
  logic                 tck_reg;
  logic                 tdi_reg;
  logic                 capDr_reg;
  logic                 shDr_reg;
  logic                 updDr_reg;
  logic                 extest_reg;
  logic [WORDS*32-1:0]  pat_reg;
  logic [WORDS*32-1:0]  cap_reg;
  logic [CHAIN_LEN-1:0] patEff;
  logic [7:0]           bit_reg;
  logic                 tdoS1_reg;
  logic                 tdoS2_reg;
  logic                 startPend_reg;
  logic                 done_reg;
  logic                 enPrev_reg;
  logic [7:0]           settle_reg;
  logic                 rise;
  logic                 fall;
  logic                 finish;

  assign link.tck       = tck_reg;
  assign link.tdi       = tdi_reg;
  assign link.captureDr = capDr_reg;
  assign link.shiftDr   = shDr_reg;
  assign link.updateDr  = updDr_reg;
  assign link.extestSel = extest_reg;

  // --------------------------------------------------
  // Link clock
  // --------------------------------------------------
  // 160 ns period leaves hold well inside its limit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_reg <= 4'h0;
      tck_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 4'h1;
      if (div_reg == 4'(TCK_DIV - 1)) tck_reg <= 1'b1;
      if (div_reg == 4'(TCK_HALF - 1)) tck_reg <= 1'b0;
    end
  end

  assign rise   = (div_reg == 4'(TCK_DIV - 1));
  assign fall   = (div_reg == 4'(TCK_HALF - 1));
  assign finish = fall && (state_reg == ST_UPD);

  // Returned data, two stages before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tdoS1_reg <= 1'b0;
      tdoS2_reg <= 1'b0;
    end else begin
      tdoS1_reg <= link.tdo;
      tdoS2_reg <= tdoS1_reg;
    end
  end

  // --------------------------------------------------
  // Pattern guards
  // --------------------------------------------------
  // Unsafe patterns are corrected rather than sent
  always_comb begin
    patEff = pat_reg[CHAIN_LEN-1:0];
    if (!patEff[HOLD_BIT]) patEff[DAC_HI:DAC_LO] = DAC_MID;
    for (int p = 0; p < 8; p++) begin
      if (patEff[CONV_EN] && patEff[MUX_LO+p]) begin
        patEff[bsc_pa_data(p)-:3] = 3'h0;
      end
    end
  end

  // --------------------------------------------------
  // Scan sequence
  // --------------------------------------------------
  // Link outputs move with the falling tck
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      capDr_reg <= 1'b0;
      shDr_reg  <= 1'b0;
      updDr_reg <= 1'b0;
      tdi_reg   <= 1'b0;
      bit_reg   <= 8'h0;
    end else if (fall) begin
      case (state_reg)
        ST_IDLE: begin
          if (startPend_reg && settle_reg == 8'h0) begin
            capDr_reg <= 1'b1;
            state_reg <= ST_CAP;
          end
        end
        ST_CAP: begin
          capDr_reg <= 1'b0;
          shDr_reg  <= 1'b1;
          tdi_reg   <= patEff[0];
          bit_reg   <= 8'h0;
          state_reg <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (bit_reg == 8'(CHAIN_LEN - 1)) begin
            shDr_reg  <= 1'b0;
            updDr_reg <= 1'b1;
            state_reg <= ST_UPD;
          end else begin
            bit_reg <= bit_reg + 8'h1;
            tdi_reg <= patEff[bit_reg + 8'h1];
          end
        end
        ST_UPD: begin
          updDr_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Result bits arrive while the next pattern goes in
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cap_reg <= '0;
    end else if (rise && state_reg == ST_SHIFT) begin
      cap_reg[bit_reg] <= tdoS2_reg;
    end
  end

  // Converter settle wait after enable first goes out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enPrev_reg <= 1'b0;
      settle_reg <= 8'h0;
    end else if (finish) begin
      enPrev_reg <= patEff[CONV_EN];
      if (patEff[CONV_EN] && !enPrev_reg) settle_reg <= 8'(SETTLE_CYC);
    end else if (settle_reg != 8'h0) begin
      settle_reg <= settle_reg - 8'h1;
    end
  end

  // --------------------------------------------------
  // Register port
  // --------------------------------------------------
  // Pattern words, start and instruction select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pat_reg       <= '0;
      extest_reg    <= 1'b0;
      startPend_reg <= 1'b0;
    end else begin
      if (wrEn && addr < CAP_BASE) pat_reg[addr[4:2]*32 +: 32] <= wrData;
      if (wrEn && addr == CTRL_ADDR) extest_reg <= wrData[CTRL_EXTEST];
      if (wrEn && addr == CTRL_ADDR && wrData[CTRL_START]) begin
        startPend_reg <= 1'b1;
      end else if (fall && state_reg == ST_IDLE && settle_reg == 8'h0) begin
        startPend_reg <= 1'b0;
      end
    end
  end

  // Done is sticky; completion beats a clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if (wrEn && addr == STAT_ADDR && wrData[STAT_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData <= 32'h0;
    end else if (rdEn) begin
      rdData <= 32'h0;
      if (addr < CAP_BASE) rdData <= pat_reg[addr[4:2]*32 +: 32];
      else if (addr < CTRL_ADDR) rdData <= cap_reg[addr[4:2]*32 +: 32];
      else if (addr == CTRL_ADDR) rdData[CTRL_EXTEST] <= extest_reg;
      else if (addr == STAT_ADDR) begin
        rdData[STAT_BUSY]   <= (state_reg != ST_IDLE) || startPend_reg;
        rdData[STAT_DONE]   <= done_reg;
        rdData[STAT_DEC]    <= cap_reg[CONV_DEC];
        rdData[STAT_SETTLE] <= (settle_reg != 8'h0);
      end
    end
  end
endmodule : bsc_test_ctrl
`default_nettype wire

// File: test/boundary_scan_chain_adc_test_test.sv
// Bench joining controller and chain through the link.
// Assumes 100 MHz ref_clk; the device has its own reset.
`timescale 1ns/1ns
`default_nettype none
module boundary_scan_chain_adc_test_test;
  import bsc_pkg::*;
  // ----
  // Signals
  // ----
  logic         ref_clk, rst, devRst, wrEn, rdEn, compIn;
  logic [7:0]   addr, portEPad, portAData;
  logic [31:0]  wrData, rdData;
  logic [39:0]  coreAnalog, analogOut;
  logic [23:0]  corePortE, portEOut;
  logic [133:0] coreRest, restPad, restOut;
  logic [9:0]   dacCode;
  logic         convEnable, holdCtrl, decision, dummyBusy;
  int           miscompares, n_checks, cycles;
  bsc_link_if lnk();
  bsc_test_ctrl u_bsc_test_ctrl (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .link(lnk));
  bsc_chain_dev u_bsc_chain_dev (.link(lnk), .rst(devRst), .coreAnalog(coreAnalog),
    .corePortE(corePortE), .coreRest(coreRest), .compIn(compIn), .portEPad(portEPad),
    .restPad(restPad), .analogOut(analogOut), .portEOut(portEOut), .restOut(restOut),
    .portAData(portAData), .dacCode(dacCode), .convEnable(convEnable), .holdCtrl(holdCtrl),
    .decision(decision), .dummyBusy(dummyBusy));
  bsc_link_properties u_bsc_link_properties (.ref_clk(ref_clk), .rst(rst), .devRst(devRst),
    .tck(lnk.tck), .tdi(lnk.tdi), .tdo(lnk.tdo), .captureDr(lnk.captureDr),
    .shiftDr(lnk.shiftDr), .updateDr(lnk.updateDr), .extestSel(lnk.extestSel));
  // ----
  // Clock and hang guard
  // ----
  always #5 ref_clk = ~ref_clk;
  // About 20 scans of 3500 cycles each fit below the ceiling
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 70000) begin
      miscompares++;
      final_report();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [197:0] act, input logic [197:0] exp, input string what);
    n_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) {addr, wrData, wrEn} <= {a, d, 1'b1};
    @(posedge ref_clk) wrEn <= 1'b0;
  endtask : wr
  // Data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk) {addr, rdEn} <= {a, 1'b1};
    @(posedge ref_clk) rdEn <= 1'b0;
    @(posedge ref_clk) d = rdData;
  endtask : rd
  // Loads, runs one scan, fetches the capture, lets outputs settle
  task automatic scan(input logic [197:0] p, input logic ext, output logic [223:0] c);
    logic [31:0] d;
    int n;
    for (int i = 0; i < 7; i++) wr(8'(4 * i), 32'({26'h0, p} >> (32 * i)));
    wr(CTRL_ADDR, {30'h0, ext, 1'b1});
    n = 0;
    d = '0;
    while (d[1] !== 1'b1 && n < 2000) begin
      rd(STAT_ADDR, d);
      n++;
    end
    chk(198'(d[1]), 198'(1), "scan done");
    wr(STAT_ADDR, 32'h2);
    for (int i = 0; i < 7; i++) begin
      rd(CAP_BASE + 8'(4 * i), d);
      c[32*i+:32] = d;
    end
    repeat (64) @(posedge ref_clk);
  endtask : scan
  function automatic logic [197:0] adc_pat(input logic [9:0] dac, input logic hold, input logic pre);
    logic [197:0] b;
    b = '0;
    b[188] = 1'b1;
    b[186:177] = dac;
    b[174] = hold;
    b[172:165] = 8'h08;
    b[160] = pre;
    b[23:21] = 3'b111; // Pin three cells, must come out cleared
    return b;
  endfunction : adc_pat
  task automatic test_reset();
    logic [31:0] d;
    repeat (4) @(posedge lnk.tck);
    chk(198'(dacCode), 198'(10'h200), "reset dac");
    chk(198'(analogOut), 198'(UPD_RST[197:158]), "reset analog");
    @(posedge ref_clk) devRst <= 1'b0;
    rd(STAT_ADDR, d);
    chk(198'(d), 198'(0), "status reset");
    rd(8'h80, d);
    chk(198'(d), 198'(0), "unmapped read");
    $display("test reset done");
  endtask : test_reset
  task automatic test_extest();
    logic [197:0] p;
    logic [223:0] c;
    logic [31:0]  d;
    p = 198'({7{32'h9e3779b9}});
    p[174] = 1'b1;
    p[188] = 1'b0;
    scan(p, 1'b0, c);
    scan(p, 1'b1, c);
    chk(198'(analogOut), 198'(p[197:158]), "analog cells");
    chk(198'(portEOut), 198'(p[157:134]), "port E cells");
    chk(198'(restOut), 198'(p[133:0]), "lower cells");
    chk(198'(dacCode), 198'(p[186:177]), "dac cells");
    chk(198'({convEnable, holdCtrl}), 198'({p[188], p[174]}), "enable hold");
    for (int n = 0; n < 8; n++) chk(198'(portAData[n]), 198'(p[14+3*n]), "port A");
    rd(CTRL_ADDR, d);
    chk(198'(d), 198'(32'h2), "mode readback");
    $display("test extest done");
  endtask : test_extest
  task automatic test_adc();
    logic [223:0] c;
    logic [31:0]  d;
    scan(adc_pat(DAC_MID, 1'b1, 1'b1), 1'b0, c);
    scan(adc_pat(10'h123, 1'b0, 1'b1), 1'b1, c);
    chk(198'(dacCode), 198'(DAC_MID), "dac in sample");
    chk(198'(restOut[23:21]), 198'(0), "pin cells");
    scan(adc_pat(DAC_MID, 1'b1, 1'b1), 1'b1, c);
    scan(adc_pat(10'h123, 1'b1, 1'b1), 1'b1, c);
    compIn <= 1'b0;
    scan(adc_pat(10'h123, 1'b1, 1'b0), 1'b1, c);
    scan(adc_pat(DAC_MID, 1'b1, 1'b1), 1'b1, c);
    chk(198'(c[193]), 198'(0), "lower limit");
    scan(adc_pat(DAC_MID, 1'b0, 1'b1), 1'b1, c);
    scan(adc_pat(DAC_MID, 1'b1, 1'b1), 1'b1, c);
    scan(adc_pat(10'h143, 1'b1, 1'b1), 1'b1, c);
    compIn <= 1'b1;
    scan(adc_pat(10'h143, 1'b1, 1'b0), 1'b1, c);
    scan(adc_pat(DAC_MID, 1'b1, 1'b1), 1'b1, c);
    chk(198'(c[193]), 198'(1), "upper limit");
    compIn <= 1'b0;
    scan(adc_pat(DAC_MID, 1'b1, 1'b1), 1'b1, c);
    chk(198'(c[193]), 198'(1), "latch held");
    rd(STAT_ADDR, d);
    chk(198'(d[2]), 198'(1), "status decision");
    $display("test adc done");
  endtask : test_adc
  task automatic test_dummy();
    int cnt;
    cnt = 0;
    wr(CTRL_ADDR, 32'h0);
    repeat (64) @(posedge ref_clk);
    coreAnalog[30] <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(posedge lnk.tck);
      if (dummyBusy === 1'b1) cnt++;
    end
    chk(198'(cnt), 198'(DUMMY_STEPS), "dummy length");
    $display("test dummy done");
  endtask : test_dummy
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // ----
  // Main sequence
  // ----
  initial begin
    {ref_clk, wrEn, rdEn, compIn, addr, wrData} = '0;
    {coreAnalog, corePortE, coreRest, portEPad, restPad} = '0;
    {miscompares, n_checks, cycles} = '0;
    rst = 1'b1;
    devRst = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_extest();
    test_adc();
    test_dummy();
    final_report();
  end
endmodule : boundary_scan_chain_adc_test_test
`default_nettype wire

// File: test/bsc_link_properties.sv
// Checker of the scan link between controller and chain.
// Assumes tck comes from the controller's divider.
`timescale 1ns/1ns
`default_nettype none
module bsc_link_properties (
  // Clocks and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic devRst,
  // Link
  input wire logic tck,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic captureDr,
  input wire logic shiftDr,
  input wire logic updateDr,
  input wire logic extestSel
);
  // ----
  // Helper logic
  // ----
  // Counts shift edges; a short count would drop cells
  logic [7:0] shiftCnt;
  always_ff @(posedge tck) begin
    if (devRst || !shiftDr) shiftCnt <= 8'h00;
    else shiftCnt <= shiftCnt + 8'h01;
  end
  // ----
  // Properties
  // ----
  AST_NO_OVERLAP: assert property (@(posedge ref_clk) disable iff (rst)
    !(captureDr && shiftDr) && !(shiftDr && updateDr) && !(captureDr && updateDr))
    else $error("link strobes overlap");
  AST_CAP_TO_SHIFT: assert property (@(posedge tck) disable iff (devRst)
    captureDr |=> shiftDr && !captureDr) else $error("capture not followed by shift");
  AST_SHIFT_LEN: assert property (@(posedge tck) disable iff (devRst)
    $fell(shiftDr) |-> shiftCnt == 8'hc6) else $error("shift length wrong");
  AST_UPD_AFTER_SHIFT: assert property (@(posedge tck) disable iff (devRst)
    $fell(shiftDr) |-> updateDr ##1 !updateDr) else $error("update not one period");
  AST_TCK_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(tck) |-> ##1 tck[*7] ##1 !tck) else $error("tck high phase wrong");
  AST_TCK_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(tck) |-> ##1 !tck[*7] ##1 tck) else $error("tck low phase wrong");
  AST_TDO_STABLE: assert property (@(posedge ref_clk) disable iff (rst || devRst)
    tck && $past(tck) |-> $stable(tdo)) else $error("tdo moved while tck high");
  AST_TDI_STABLE: assert property (@(posedge ref_clk) disable iff (rst)
    tck && $past(tck) |-> $stable(tdi)) else $error("tdi moved while tck high");
  AST_MODE_STEADY: assert property (@(posedge ref_clk) disable iff (rst)
    shiftDr |-> $stable(extestSel)) else $error("mode changed in scan");
endmodule : bsc_link_properties
`default_nettype wire
